// [inc/pdt_consts.vh]
`ifndef PDT_CONSTS_VH
`define PDT_CONSTS_VH
// register indices; byte address is four times the index
`define PDT_IDX_COMBINE 8'h20
`define PDT_IDX_DEADTIME 8'h22
`define PDT_IDX_TRIGGER 8'h23
`define PDT_IDX_WPROT 8'h30
// deadtime_control fields
`define PDT_DEADTIME_PRESCALE_HI 7
`define PDT_DEADTIME_PRESCALE_LO 6
`define PDT_DEADTIME_COUNT_HI 5
`define PDT_DEADTIME_COUNT_LO 0
`define PDT_DEADTIME_PRESCALE_DIV4 2'h2
`define PDT_DEADTIME_PRESCALE_DIV16 2'h3
`define PDT_DIV4_SHIFT 4'h2
`define PDT_DIV16_SHIFT 4'h4
// trigger_control fields
`define PDT_TRIGGER_FLAG_BIT 7
`define PDT_INITEN_BIT 6
`define PDT_CH1EN_BIT 5
`define PDT_CH0EN_BIT 4
`define PDT_CH5EN_BIT 3
`define PDT_CH4EN_BIT 2
`define PDT_CH3EN_BIT 1
`define PDT_CH2EN_BIT 0
// channel_pair_combine fields
`define PDT_COMB_LO 0
`define PDT_PAIR_DEADTIME_EN_LO 4
// write protect register
`define PDT_WPOFF_BIT 0
// reset values
`define PDT_RST_COMBINE 8'h00
`define PDT_RST_DEADTIME 8'h00
`define PDT_RST_TRIGGER 8'h00
`define PDT_RST_WPOFF 1'b0
`endif

// [rtl/pdt_ctrl.v]
// Operation
// - combine bit 1 pairs channels n and n+1; 0 keeps them independent
// - combine, prescale and deadtime count writable only when write_protect_off is 1
// - prescale bits 7-6: 0x divides by 1, 10 by 4, 11 by 16
// - one prescale and one deadtime count shared by all channels
// - deadtime count inserts that many prescaled counts, zero none, up to 63
// - inserted delay in clocks is prescale factor times deadtime count
// - trigger flag bit 7 set by hardware on any channel trigger
// - flag cleared by read while set then write 0; writing 1 ignored
// - trigger between clearing read and write restarts clear, flag stays set
// - bit 6 enables trigger when counter equals its initial value
// - bit 5 enables channel 1 trigger on counter matching its value
// - bit 4 enables channel 0 trigger on counter matching its value
// - bits 3,2,1,0 enable channels 5,4,3,2 triggers on own match
// - channels 6 and 7 never produce channel triggers
// - several enabled channels give separate triggers within one period
// - per-pair deadtime enable, also write protected
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "pdt_consts.vh"
module pdt_ctrl #(
    parameter CNT_W = 16,
    parameter NCH = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [CNT_W-1:0] timer_count,
    input wire [CNT_W-1:0] timer_init_value,
    input wire [6*CNT_W-1:0] channel_value,
    input wire [NCH-1:0] pwm_raw,
    output reg [NCH-1:0] pwm_out,
    output reg [5:0] ch_trig,
    output reg init_trig
);
    localparam NPAIR = NCH / 2;

    reg [7:0] combine_q;
    reg [7:0] deadtime_q;
    reg [6:0] trig_en_q;
    reg trigger_flag_q;
    reg clr_armed_q;
    reg write_protect_off_q;
    reg [5:0] match_prev_q;
    reg init_prev_q;
    reg [9:0] dt_cnt_q [0:NCH-1];
    reg [NCH-1:0] pwm_q;

    wire setup = psel & ~penable;
    wire access = psel & penable & pready;
    wire wr_acc = access & pwrite;
    wire rd_acc = access & ~pwrite;
    // word index match for one register
    function idx_is;
        input [9:0] word;
        input [7:0] target;
        begin
            idx_is = (word == {2'b00, target});
        end
    endfunction

    // misaligned accesses hit nothing, so they never write
    wire aligned = (paddr[1:0] == 2'b00);
    wire [9:0] idx = paddr[11:2];
    wire hit_comb = aligned & idx_is(idx, `PDT_IDX_COMBINE);
    wire hit_dt = aligned & idx_is(idx, `PDT_IDX_DEADTIME);
    wire hit_trig = aligned & idx_is(idx, `PDT_IDX_TRIGGER);
    wire hit_wp = aligned & idx_is(idx, `PDT_IDX_WPROT);
    wire mapped = hit_comb | hit_dt | hit_trig | hit_wp;

    // shared deadtime length in system clocks
    function [9:0] dt_cycles;
        input [7:0] dt;
        reg [9:0] val;
        begin
            val = {4'h0, dt[`PDT_DEADTIME_COUNT_HI:`PDT_DEADTIME_COUNT_LO]};
            case (dt[`PDT_DEADTIME_PRESCALE_HI:`PDT_DEADTIME_PRESCALE_LO])
                `PDT_DEADTIME_PRESCALE_DIV4: dt_cycles = val << `PDT_DIV4_SHIFT;
                `PDT_DEADTIME_PRESCALE_DIV16: dt_cycles = val << `PDT_DIV16_SHIFT;
                2'h0, 2'h1: dt_cycles = val;
                default: dt_cycles = val;
            endcase
        end
    endfunction

    // enable bit of a trigger channel
    function ch_enable;
        input [6:0] en;
        input integer ch;
        begin
            case (ch)
                0: ch_enable = en[`PDT_CH0EN_BIT];
                1: ch_enable = en[`PDT_CH1EN_BIT];
                2: ch_enable = en[`PDT_CH2EN_BIT];
                3: ch_enable = en[`PDT_CH3EN_BIT];
                4: ch_enable = en[`PDT_CH4EN_BIT];
                5: ch_enable = en[`PDT_CH5EN_BIT];
                default: ch_enable = 1'b0;
            endcase
        end
    endfunction

    // match detection, one pulse per new match
    reg [5:0] match_now;
    reg [5:0] trig_d;
    integer m;
    always @* begin
        for (m = 0; m < 6; m = m + 1) begin
            match_now[m] = (timer_count == channel_value[m*CNT_W +: CNT_W]);
            trig_d[m] = match_now[m] & ~match_prev_q[m] & ch_enable(trig_en_q, m);
        end
    end
    wire init_match = (timer_count == timer_init_value);
    wire init_d = init_match & ~init_prev_q & trig_en_q[`PDT_INITEN_BIT];
    wire any_trig = |trig_d;

    // apb read mux
    reg [7:0] rd_d;
    always @* begin
        rd_d = 8'h00;
        if (hit_comb) begin
            rd_d = combine_q;
        end else if (hit_dt) begin
            rd_d = deadtime_q;
        end else if (hit_trig) begin
            rd_d = {trigger_flag_q, trig_en_q};
        end else if (hit_wp) begin
            rd_d = {7'h00, write_protect_off_q};
        end
    end

    // apb slave, no wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= {24'h000000, (pwrite | ~mapped) ? 8'h00 : rd_d};
                pslverr <= ~mapped;
            end else if (access) begin
                prdata <= 32'h00000000;
                pslverr <= 1'b0;
            end
        end
    end

    // write protect register, never itself protected
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_protect_off_q <= `PDT_RST_WPOFF;
        end else if (wr_acc && hit_wp) begin
            write_protect_off_q <= pwdata[`PDT_WPOFF_BIT];
        end
    end

    // pair combine and deadtime enables
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            combine_q <= `PDT_RST_COMBINE;
        end else if (wr_acc && hit_comb && write_protect_off_q) begin
            combine_q <= pwdata[7:0];
        end
    end

    // shared deadtime prescale and count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deadtime_q <= `PDT_RST_DEADTIME;
        end else if (wr_acc && hit_dt && write_protect_off_q) begin
            deadtime_q <= pwdata[7:0];
        end
    end

    // trigger enables, not protected
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_en_q <= 7'h00;
        end else if (wr_acc && hit_trig) begin
            trig_en_q <= pwdata[6:0];
        end
    end

    // trigger flag, a new trigger wins over a clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_flag_q <= 1'b0;
        end else if (any_trig) begin
            trigger_flag_q <= 1'b1;
        end else if (wr_acc && hit_trig && clr_armed_q && !pwdata[`PDT_TRIGGER_FLAG_BIT]) begin
            trigger_flag_q <= 1'b0;
        end
    end

    // clear sequence, armed by a read of a set flag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_armed_q <= 1'b0;
        end else if (any_trig) begin
            clr_armed_q <= 1'b0;
        end else if (wr_acc && hit_trig) begin
            clr_armed_q <= 1'b0;
        end else if (rd_acc && hit_trig && trigger_flag_q) begin
            clr_armed_q <= 1'b1;
        end
    end

    // channel trigger pulses
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_prev_q <= 6'h00;
            ch_trig <= 6'h00;
        end else begin
            match_prev_q <= match_now;
            ch_trig <= trig_d;
        end
    end

    // initial value trigger pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_prev_q <= 1'b0;
            init_trig <= 1'b0;
        end else begin
            init_prev_q <= init_match;
            init_trig <= init_d;
        end
    end

    // channel sources after pair combining
    reg [NCH-1:0] src;
    reg [NCH-1:0] dt_on;
    integer p;
    always @* begin
        src = pwm_raw;
        dt_on = {NCH{1'b0}};
        for (p = 0; p < NPAIR; p = p + 1) begin
            if (combine_q[`PDT_COMB_LO + p]) begin
                src[2*p+1] = ~pwm_raw[2*p];
            end
            dt_on[2*p] = combine_q[`PDT_PAIR_DEADTIME_EN_LO + p];
            dt_on[2*p+1] = combine_q[`PDT_PAIR_DEADTIME_EN_LO + p];
        end
    end

    wire [9:0] dt_len = dt_cycles(deadtime_q);

    // deadtime counters, restarted whenever the source drops
    integer c;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (c = 0; c < NCH; c = c + 1) begin
                dt_cnt_q[c] <= 10'h000;
            end
        end else begin
            for (c = 0; c < NCH; c = c + 1) begin
                if (!src[c]) begin
                    dt_cnt_q[c] <= 10'h000;
                end else if (!pwm_q[c] && dt_on[c] && dt_cnt_q[c] < dt_len) begin
                    dt_cnt_q[c] <= dt_cnt_q[c] + 10'h001;
                end
            end
        end
    end

    // outputs rise after the deadtime, fall at once
    integer q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_q <= {NCH{1'b0}};
        end else begin
            for (q = 0; q < NCH; q = q + 1) begin
                if (!src[q]) begin
                    pwm_q[q] <= 1'b0;
                end else if (!dt_on[q] || dt_cnt_q[q] >= dt_len) begin
                    pwm_q[q] <= 1'b1;
                end
            end
        end
    end

    always @* begin
        pwm_out = pwm_q;
    end
endmodule // pdt_ctrl

// [verification/pdt_trig_sink.sv]
`timescale 1ns/1ps
module pdt_trig_sink (
    input wire pclk,
    input wire presetn,
    input wire [5:0] ch_trig,
    input wire init_trig,
    output reg [7:0] n_trig
);
    // consumer tallies every separate trigger pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_trig <= 8'h00;
        end else begin
            n_trig <= n_trig + 8'($countones({ch_trig, init_trig}));
        end
    end
endmodule // pdt_trig_sink

// [verification/pdt_ctrl_props.sv]
`timescale 1ns/1ps
module pdt_ctrl_props #(parameter CNT_W = 16, parameter NCH = 8) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [CNT_W-1:0] timer_count,
    input wire [CNT_W-1:0] timer_init_value,
    input wire [6*CNT_W-1:0] channel_value,
    input wire [NCH-1:0] pwm_raw,
    input wire [NCH-1:0] pwm_out,
    input wire [5:0] ch_trig,
    input wire init_trig
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ch0_on_match: assert property (ch_trig[0] |-> $past(timer_count) == $past(channel_value[0 +: CNT_W]))
        else $error("ch0 trigger without match");
    a_ch1_on_match: assert property (ch_trig[1] |-> $past(timer_count) == $past(channel_value[CNT_W +: CNT_W]))
        else $error("ch1 trigger without match");
    a_ch5_on_match: assert property (ch_trig[5] |-> $past(timer_count) == $past(channel_value[5*CNT_W +: CNT_W]))
        else $error("ch5 trigger without match");
    a_init_on_match: assert property (init_trig |-> $past(timer_count) == $past(timer_init_value))
        else $error("init trigger without match");
    a_trig_one_pulse: assert property (ch_trig[3] |=> !ch_trig[3])
        else $error("ch3 trigger longer than one cycle");
    a_rise_needs_src: assert property ($rose(pwm_out[0]) |-> $past(pwm_raw[0]))
        else $error("output rose without source");
    a_fall_at_once: assert property ($fell(pwm_raw[0]) |=> !pwm_out[0])
        else $error("falling edge delayed");
    a_pair_source: assert property ($rose(pwm_out[1]) |-> $past(pwm_raw[1]) || !$past(pwm_raw[0]))
        else $error("odd channel rose from no source");
    cover property (init_trig);
    cover property ($rose(pwm_out[0]));
    cover property (pready && pslverr);
endmodule // pdt_ctrl_props
bind pdt_ctrl pdt_ctrl_props #(.CNT_W(CNT_W), .NCH(NCH)) u_props (.*);

// [verification/tb_pdt_ctrl.sv]
`timescale 1ns/1ps
`include "pdt_consts.vh"
module tb_pdt_ctrl;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, r;
    reg [15:0] timer_count = 16'h0064, timer_init_value = 16'h0001;
    reg [95:0] channel_value;
    reg [7:0] pwm_raw = 0;
    reg [23:0] dts = 24'h83C205, dex = 24'h0E2207;
    wire [31:0] prdata;
    wire pready, pslverr, init_trig;
    wire [7:0] pwm_out, n_trig;
    wire [5:0] ch_trig;
    integer n_mismatch = 0, checked = 0, cyc = 0, i, n;
    always #4 pclk = ~pclk;
    pdt_ctrl uut (.*);
    pdt_trig_sink sink (.*);
    task give_verdict;
        begin
            if (n_mismatch == 0 && checked > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] s, input [31:0] x);
        begin
            checked = checked + 1;
            if (s !== x) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch %s exp %h seen %h", nm, x, s);
            end
        end
    endtask
    task xfer(input w, input [9:0] a, input [7:0] d);
        begin
            @(posedge pclk);
            psel <= 1'h1;
            pwrite <= w;
            paddr <= {a, 2'h0};
            pwdata <= {24'h000000, d};
            @(posedge pclk);
            penable <= 1'h1;
            @(posedge pclk);
            while (pready !== 1'h1) @(posedge pclk);
            r = prdata;
            e = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
        end
    endtask
    task rdc(input string nm, input [9:0] a, input [31:0] x);
        begin
            xfer(1'h0, a, 8'h00);
            chk(nm, r, x);
        end
    endtask
    task tick(input [15:0] v);
        begin
            @(posedge pclk);
            timer_count <= v;
            repeat (3) @(posedge pclk);
        end
    endtask
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin
            n_mismatch = n_mismatch + 1;
            give_verdict;
        end
    end
    initial begin
        for (i = 0; i < 6; i = i + 1) channel_value[i*16 +: 16] = i + 2;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        rdc("trig reset", `PDT_IDX_TRIGGER, 32'h0);
        xfer(1'h1, `PDT_IDX_DEADTIME, 8'h83);
        rdc("dt locked", `PDT_IDX_DEADTIME, 32'h0);
        xfer(1'h0, 10'h3F, 8'h00);
        chk("unmapped", e, 32'h1);
        xfer(1'h1, `PDT_IDX_WPROT, 8'h01);
        xfer(1'h1, `PDT_IDX_COMBINE, 8'h01);
        tick(16'h0064);
        chk("combined", pwm_out[1], 32'h1);
        xfer(1'h1, `PDT_IDX_COMBINE, 8'h10);
        tick(16'h0064);
        chk("apart", pwm_out[1], 32'h0);
        for (i = 0; i < 3; i = i + 1) begin
            xfer(1'h1, `PDT_IDX_DEADTIME, dts[23-8*i -: 8]);
            @(posedge pclk);
            pwm_raw <= 8'h01;
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (pwm_out[0] !== 1'h1 && n < 99);
            chk("deadtime", n, dex[23-8*i -: 8]);
            pwm_raw <= 8'h00;
            repeat (2) @(posedge pclk);
        end
        xfer(1'h1, `PDT_IDX_TRIGGER, 8'h7F);
        for (i = 0; i < 12; i = i + 1) tick(i);
        chk("trig count", n_trig, 32'h7);
        rdc("flag set", `PDT_IDX_TRIGGER, 32'hFF);
        xfer(1'h1, `PDT_IDX_TRIGGER, 8'hFF);
        rdc("write one", `PDT_IDX_TRIGGER, 32'hFF);
        xfer(1'h1, `PDT_IDX_TRIGGER, 8'h7F);
        rdc("cleared", `PDT_IDX_TRIGGER, 32'h7F);
        tick(16'h0002);
        rdc("ch0 sets", `PDT_IDX_TRIGGER, 32'hFF);
        tick(16'h0003);
        xfer(1'h1, `PDT_IDX_TRIGGER, 8'h7F);
        rdc("clear raced", `PDT_IDX_TRIGGER, 32'hFF);
        give_verdict;
    end
endmodule // tb_pdt_ctrl
